// ### tcp_counter.sv
// Up-counter with comparator A (16 bit) and comparator P (upper byte)
`default_nettype none
module tcp_counter
   import tcp_pkg::*;
#(
   parameter int unsigned CW = CNT_W,
   parameter int unsigned PW = PER_W
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run_rise,
   input wire logic step,
   input wire logic clr_on_a,
   input wire logic clr_on_p,
   input wire logic [CW-1:0] cmp_a,
   input wire logic [PW-1:0] period,
   output logic [CW-1:0] count,
   output logic a_hit,
   output logic p_hit
);
   typedef struct packed {
      logic [CW-1:0] count;
   } tcp_cnt_state_t;

   tcp_cnt_state_t st_r;
   tcp_cnt_state_t st_nxt;
   logic [CW-1:0] inc;

   always_comb
   begin
      inc = st_r.count + CW'(1);
      a_hit = step && (inc == cmp_a);
      // Zero period: the match falls on the wrap, giving a full 65536 count span
      if (period == '0)
      begin
         p_hit = step && (st_r.count == '1); // R4
      end
      else
      begin
         p_hit = step && (inc[CW-1 -: PW] == period) && (inc[CW-PW-1:0] == '0); // R6
      end
      st_nxt = st_r;
      if (run_rise)
      begin
         st_nxt.count = '0; // R19
      end
      else if (step)
      begin
         if ((a_hit && clr_on_a) || (p_hit && clr_on_p)) // R3
         begin
            st_nxt.count = '0;
         end
         else
         begin
            st_nxt.count = inc; // R21
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign count = st_r.count;
endmodule
`default_nettype wire

// ### tcp_load.sv
// External load on the timer pin: pull-up, high-time and edge counters
`default_nettype none
module tcp_load
(
   input wire logic clk,
   input wire logic drv,
   input wire logic oe,
   input wire logic clr,
   output logic pin,
   output logic [15:0] hi_cnt,
   output logic [7:0] edges
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last;
   // Released pin floats to the pull-up level, never to the last driven value
   assign pin = oe ? drv : 1'b1;
   always_ff @(posedge clk)
   begin
      last <= pin;
      if (clr)
      begin
         hi_cnt <= 16'h0;
         edges <= 8'h0;
      end
      else
      begin
         hi_cnt <= hi_cnt + {15'h0, pin};
         edges <= edges + {7'h0, pin != last};
      end
   end
endmodule
`default_nettype wire

// ### tcp_pkg.sv
// Shared constants, modes and bus carrier types of the timer compare/PWM block
`default_nettype none
package tcp_pkg;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned PER_W = 8;
   localparam int unsigned ADDR_W = 8;

   localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CMPA = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h14;

   // Control register 0 fields
   localparam int unsigned PAUSE_BIT = 7;
   localparam int unsigned CLKSEL_LSB = 4;
   localparam int unsigned RUN_BIT = 3;
   localparam logic [7:0] CTRL0_WMASK = 8'hF8;
   // Control register 1 (timer_control_one) fields
   localparam int unsigned MODE_LSB = 6;
   localparam int unsigned PIN_ACT_LSB = 4;
   localparam int unsigned INIT_LVL_BIT = 3;
   localparam int unsigned INVERT_BIT = 2;
   localparam int unsigned SWAP_BIT = 1;
   localparam int unsigned CLR_SEL_BIT = 0;
   // Flag register fields
   localparam int unsigned FLAG_A_BIT = 0;
   localparam int unsigned FLAG_P_BIT = 1;

   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [CNT_W-1:0] CMPA_RST = 16'h0000;
   localparam logic [PER_W-1:0] PERIOD_RST = 8'h00;

   typedef enum logic [1:0] {MODE_CMP, MODE_CAP, MODE_PWM, MODE_TMR} tcp_mode_t;

   // Pin action, compare-match meaning
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   // Pin action, PWM meaning
   localparam logic [1:0] ACT_INACTIVE = 2'h0;
   localparam logic [1:0] ACT_ACTIVE = 2'h1;
   localparam logic [1:0] ACT_PWM = 2'h2;

   // Timer clock select and prescaler masks
   localparam logic [2:0] CLK_DIV4 = 3'h0;
   localparam logic [2:0] CLK_DIV1 = 3'h1;
   localparam logic [2:0] CLK_DIV16 = 3'h2;
   localparam logic [2:0] CLK_DIV64 = 3'h3;
   localparam logic [5:0] MASK_DIV1 = 6'h00;
   localparam logic [5:0] MASK_DIV4 = 6'h03;
   localparam logic [5:0] MASK_DIV16 = 6'h0F;
   localparam logic [5:0] MASK_DIV64 = 6'h3F;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } tcp_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tcp_axi_rsp_t;
endpackage
`default_nettype wire

// ### tcp_timer.sv
// Timer compare/PWM unit with AXI4-Lite register access
// Functional notes
// R1: Invert bit reverses the output pin; no effect in timer/counter mode.
// R2: Swap 0: P sets PWM period, A duty; swap 1: the reverse.
// R3: Clear select 1 clears on A match; 0 clears on P match or overflow.
// R4: Overflow clearing only with period value zero, giving 65536 clocks.
// R5: Clear select is ignored in PWM, single pulse and capture modes.
// R6: Period value compares counter bits 15..8; N gives N times 256 clocks.
// R7: Mode 00 compare, 11 timer/counter, 10 PWM with pin action 10.
// R8: Compare mode, clear select 0: both match flags set on their matches.
// R9: Compare mode, clear select 1: only flag A; flag P never set.
// R10: Software must not set compare A to zero in compare mode.
// R11: Compare mode: pin changes only on A match, never on P match.
// R12: A match drives pin high, low or toggles per action; zero does nothing.
// R13: Each run bit rising edge forces the pin to the initial level.
// R14: Timer/counter mode behaves as compare mode but leaves the pin undriven.
// R15: PWM: period comparator clears counter; the other sets duty.
// R16: PWM: flag A on A match, flag P on P match.
// R17: PWM: initial bit sets polarity, action enables/forces, invert reverses.
// R18: Compare pin action: 00 none, 01 low, 10 high, 11 toggle.
// R19: Run rising edge zeroes counter; falling edge holds the count.
// R20: PWM action: 00 inactive, 01 active, 10 waveform, 11 single pulse (11 only drives the inactive level here).
// R21: Counter steps on each timer tick while running and not paused.
// R22: PWM output active from period clear until duty match, then inactive.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
module tcp_timer
   import tcp_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire tcp_axi_req_t AXI_REQ,
   output tcp_axi_rsp_t AXI_RSP,
   input wire logic TICK_EXT,
   output logic TMR_OUT,
   output logic TMR_OUT_OE
);
   typedef struct packed {
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [CNT_W-1:0] cmpa;
      logic [PER_W-1:0] period;
      logic flag_a;
      logic flag_p;
      logic run_d;
      logic [5:0] presc;
      logic out_lvl;
      logic pwm_act;
      logic pin;
      logic pin_oe;
      logic aw_held;
      logic [ADDR_W-1:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tcp_state_t;

   tcp_state_t st_r;
   tcp_state_t st_nxt;

   logic [CNT_W-1:0] count;
   logic a_hit;
   logic p_hit;
   logic run;
   logic run_rise;
   logic tick;
   logic step;
   logic clr_on_a;
   logic clr_on_p;
   tcp_mode_t mode;
   logic [1:0] act;
   logic init_lvl;
   logic swap;
   logic clr_sel;
   logic period_hit;
   logic duty_hit;
   logic set_p;
   logic aw_go;
   logic w_go;
   logic ar_go;
   logic do_wr;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [1:0] clr_flags;
   logic lvl;

   function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input int unsigned lane);
      logic [7:0] res;
      res = strb[lane] ? data[lane*8 +: 8] : old;
      return res;
   endfunction

   function automatic logic [5:0] presc_mask(input logic [2:0] sel);
      logic [5:0] m;
      case (sel)
         CLK_DIV1: m = MASK_DIV1;
         CLK_DIV4: m = MASK_DIV4;
         CLK_DIV16: m = MASK_DIV16;
         CLK_DIV64: m = MASK_DIV64;
         default: m = MASK_DIV1;
      endcase
      return m;
   endfunction

   tcp_counter #(
      .CW(CNT_W),
      .PW(PER_W)
   ) u_counter (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .run_rise(run_rise),
      .step(step),
      .clr_on_a(clr_on_a),
      .clr_on_p(clr_on_p),
      .cmp_a(st_r.cmpa),
      .period(st_r.period),
      .count(count),
      .a_hit(a_hit),
      .p_hit(p_hit)
   );

   always_comb
   begin
      mode = tcp_mode_t'(st_r.ctrl1[MODE_LSB +: 2]); // R7
      act = st_r.ctrl1[PIN_ACT_LSB +: 2];
      init_lvl = st_r.ctrl1[INIT_LVL_BIT];
      swap = st_r.ctrl1[SWAP_BIT];
      clr_sel = st_r.ctrl1[CLR_SEL_BIT];
      run = st_r.ctrl0[RUN_BIT];
      run_rise = run && !st_r.run_d; // R19
      // Upper select codes use the external tick, taken as a one-cycle synchronous pulse
      if (st_r.ctrl0[CLKSEL_LSB + 2])
      begin
         tick = TICK_EXT;
      end
      else
      begin
         tick = (st_r.presc & presc_mask(st_r.ctrl0[CLKSEL_LSB +: 3]))
                == presc_mask(st_r.ctrl0[CLKSEL_LSB +: 3]);
      end
      step = run && !st_r.ctrl0[PAUSE_BIT] && tick && !run_rise; // R21
      if (mode == MODE_PWM)
      begin
         clr_on_a = swap; // R15 R5
      end
      else
      begin
         clr_on_a = clr_sel && (mode != MODE_CAP); // R3 R5
      end
      clr_on_p = !clr_on_a;
      period_hit = swap ? a_hit : p_hit; // R2
      duty_hit = swap ? p_hit : a_hit; // R2
      // Clear select 1 in compare or timer mode never raises flag P
      set_p = p_hit && !(clr_sel && (mode == MODE_CMP || mode == MODE_TMR)); // R8 R9 R16
   end

   always_comb
   begin
      aw_go = AXI_REQ.awvalid && !st_r.aw_held && !st_r.bvalid;
      w_go = AXI_REQ.wvalid && !st_r.w_held && !st_r.bvalid;
      ar_go = AXI_REQ.arvalid && !st_r.rvalid;
      wr_addr = st_r.aw_held ? st_r.awaddr : AXI_REQ.awaddr;
      wr_data = st_r.w_held ? st_r.wdata : AXI_REQ.wdata;
      wr_strb = st_r.w_held ? st_r.wstrb : AXI_REQ.wstrb;
      do_wr = (st_r.aw_held || aw_go) && (st_r.w_held || w_go);
      clr_flags = '0;

      st_nxt = st_r;
      st_nxt.run_d = run;
      st_nxt.presc = st_r.presc + 6'h01;

      // Write channel: address and data may arrive in either order
      if (aw_go)
      begin
         st_nxt.aw_held = 1'b1;
         st_nxt.awaddr = AXI_REQ.awaddr;
      end
      if (w_go)
      begin
         st_nxt.w_held = 1'b1;
         st_nxt.wdata = AXI_REQ.wdata;
         st_nxt.wstrb = AXI_REQ.wstrb;
      end
      if (do_wr)
      begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = RESP_OKAY;
         case (wr_addr)
            OFS_CTRL0:
            begin
               st_nxt.ctrl0 = wr_byte(st_r.ctrl0, wr_data, wr_strb, 0) & CTRL0_WMASK;
            end
            OFS_CTRL1:
            begin
               st_nxt.ctrl1 = wr_byte(st_r.ctrl1, wr_data, wr_strb, 0);
            end
            OFS_CMPA:
            begin
               st_nxt.cmpa = {wr_byte(st_r.cmpa[15:8], wr_data, wr_strb, 1),
                              wr_byte(st_r.cmpa[7:0], wr_data, wr_strb, 0)};
            end
            OFS_PERIOD:
            begin
               st_nxt.period = wr_byte(st_r.period, wr_data, wr_strb, 0);
            end
            OFS_FLAGS:
            begin
               if (wr_strb[0])
               begin
                  clr_flags = wr_data[FLAG_P_BIT:FLAG_A_BIT];
               end
            end
            OFS_COUNT:
            begin
               st_nxt.bresp = RESP_OKAY;
            end
            default:
            begin
               st_nxt.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (st_r.bvalid && AXI_REQ.bready)
      begin
         st_nxt.bvalid = 1'b0;
      end

      // Read channel: one cycle from address to data
      if (ar_go)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = RESP_OKAY;
         st_nxt.rdata = '0;
         case (AXI_REQ.araddr)
            OFS_CTRL0: st_nxt.rdata[7:0] = st_r.ctrl0;
            OFS_CTRL1: st_nxt.rdata[7:0] = st_r.ctrl1;
            OFS_COUNT: st_nxt.rdata[CNT_W-1:0] = count;
            OFS_CMPA: st_nxt.rdata[CNT_W-1:0] = st_r.cmpa;
            OFS_PERIOD: st_nxt.rdata[PER_W-1:0] = st_r.period;
            OFS_FLAGS:
            begin
               st_nxt.rdata[FLAG_A_BIT] = st_r.flag_a;
               st_nxt.rdata[FLAG_P_BIT] = st_r.flag_p;
            end
            default: st_nxt.rresp = RESP_SLVERR;
         endcase
      end
      else if (st_r.rvalid && AXI_REQ.rready)
      begin
         st_nxt.rvalid = 1'b0;
      end

      // Write-one-to-clear; a match in the same cycle keeps the flag set
      st_nxt.flag_a = (st_r.flag_a && !clr_flags[FLAG_A_BIT]) || a_hit; // R8 R16
      st_nxt.flag_p = (st_r.flag_p && !clr_flags[FLAG_P_BIT]) || set_p; // R8 R9 R16

      // Compare-match output level; the run rising edge overrides a match
      if (run_rise)
      begin
         st_nxt.out_lvl = init_lvl; // R13
      end
      else if (a_hit && mode == MODE_CMP) // R11
      begin
         case (act)
            ACT_LOW: st_nxt.out_lvl = 1'b0; // R12 R18
            ACT_HIGH: st_nxt.out_lvl = 1'b1; // R12 R18
            ACT_TOGGLE: st_nxt.out_lvl = !st_r.out_lvl; // R12 R18
            default: st_nxt.out_lvl = st_r.out_lvl; // R12
         endcase
      end

      // PWM phase keeps running even while the pin is forced
      if (run_rise || period_hit)
      begin
         st_nxt.pwm_act = 1'b1; // R22
      end
      else if (duty_hit)
      begin
         st_nxt.pwm_act = 1'b0; // R22
      end

      // Registered pin; duty at or above period yields a full active cycle
      lvl = 1'b0;
      case (mode)
         MODE_CMP:
         begin
            lvl = st_nxt.out_lvl;
            st_nxt.pin_oe = 1'b1;
         end
         MODE_PWM:
         begin
            case (act)
               ACT_INACTIVE: lvl = !init_lvl; // R20 R17
               ACT_ACTIVE: lvl = init_lvl; // R20 R17
               ACT_PWM: lvl = st_nxt.pwm_act ? init_lvl : !init_lvl; // R17 R22
               default: lvl = !init_lvl; // R20
            endcase
            st_nxt.pin_oe = 1'b1;
         end
         default:
         begin
            st_nxt.pin_oe = 1'b0; // R14
         end
      endcase
      st_nxt.pin = st_nxt.pin_oe && (lvl ^ st_r.ctrl1[INVERT_BIT]); // R1
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         st_r <= '0;
         st_r.ctrl0 <= CTRL0_RST;
         st_r.ctrl1 <= CTRL1_RST;
         st_r.cmpa <= CMPA_RST;
         st_r.period <= PERIOD_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   always_comb
   begin
      AXI_RSP.awready = !st_r.aw_held && !st_r.bvalid;
      AXI_RSP.wready = !st_r.w_held && !st_r.bvalid;
      AXI_RSP.bvalid = st_r.bvalid;
      AXI_RSP.bresp = st_r.bresp;
      AXI_RSP.arready = !st_r.rvalid;
      AXI_RSP.rvalid = st_r.rvalid;
      AXI_RSP.rdata = st_r.rdata;
      AXI_RSP.rresp = st_r.rresp;
   end

   assign TMR_OUT = st_r.pin;
   assign TMR_OUT_OE = st_r.pin_oe;
endmodule
`default_nettype wire

// ### tcp_timer_checker.sv
// Port-level assertions for the timer compare/PWM block
`default_nettype none
module tcp_timer_checker
   import tcp_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire tcp_axi_req_t AXI_REQ,
   input wire tcp_axi_rsp_t AXI_RSP,
   input wire logic TICK_EXT,
   input wire logic TMR_OUT,
   input wire logic TMR_OUT_OE
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] ctl_r;
   logic [2:0] age_r;
   logic wr_now;
   assign wr_now = AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready;
   // Shadow of the mode byte; age counts quiet cycles so pin checks skip settling
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         ctl_r <= 8'h00;
         age_r <= 3'h0;
      end
      else if (wr_now)
      begin
         if (AXI_REQ.awaddr == OFS_CTRL1 && AXI_REQ.wstrb[0])
            ctl_r <= AXI_REQ.wdata[7:0];
         age_r <= 3'h0;
      end
      else if (age_r != 3'h7)
         age_r <= age_r + 3'h1;
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   sequence rd_take;
      AXI_REQ.arvalid && AXI_RSP.arready;
   endsequence
   sequence rd_bad;
      rd_take ##0 (AXI_REQ.araddr > OFS_FLAGS || AXI_REQ.araddr[1:0] != 2'h0);
   endsequence
   write_answer_a: assert property (wr_now |=> AXI_RSP.bvalid)
      else $error("write response missing");
   read_answer_a: assert property (rd_take |=> AXI_RSP.rvalid)
      else $error("read response missing");
   bresp_hold_a: assert property (AXI_RSP.bvalid && !AXI_REQ.bready
      |=> AXI_RSP.bvalid && $stable(AXI_RSP.bresp)) else $error("write response dropped");
   rdata_hold_a: assert property (AXI_RSP.rvalid && !AXI_REQ.rready
      |=> AXI_RSP.rvalid && $stable(AXI_RSP.rdata)) else $error("read data dropped");
   read_block_a: assert property (AXI_RSP.rvalid |-> !AXI_RSP.arready)
      else $error("read taken while busy");
   bad_addr_a: assert property (rd_bad
      |=> AXI_RSP.rresp == RESP_SLVERR && AXI_RSP.rdata == 32'h0) else $error("bad read ok");
   reset_idle_a: assert property ($rose(RST_N)
      |-> !AXI_RSP.bvalid && !AXI_RSP.rvalid && !TMR_OUT) else $error("not idle after reset");
   pin_release_a: assert property (!TMR_OUT_OE |-> !TMR_OUT)
      else $error("pin high while released");
   pin_enable_a: assert property (age_r == 3'h7
      |-> TMR_OUT_OE == (ctl_r[7:6] == 2'h0 || ctl_r[7:6] == 2'h2)) else $error("pin enable");
   pwm_forced_a: assert property (age_r == 3'h7 && ctl_r[7:6] == 2'h2 && !ctl_r[5]
      |-> TMR_OUT == ((ctl_r[4] ? ctl_r[3] : !ctl_r[3]) ^ ctl_r[2])) else $error("forced pwm");
endmodule
bind tcp_timer tcp_timer_checker tcp_timer_checker_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
   .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP), .TICK_EXT(TICK_EXT), .TMR_OUT(TMR_OUT),
   .TMR_OUT_OE(TMR_OUT_OE));
`default_nettype wire

// ### tcp_timer_tb_top.sv
// Self-checking bench for the timer compare/PWM block
`default_nettype none
module tcp_timer_tb_top
   import tcp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic tick = 1'b0;
   logic clr = 1'b0;
   tcp_axi_req_t req = '0;
   tcp_axi_rsp_t rsp;
   logic out, oe, pin;
   logic [15:0] hi_cnt;
   logic [7:0] edges;
   logic [31:0] rd_d;
   logic [1:0] resp;
   int fail_count = 0;
   int samples_checked = 0;
   logic [7:0] ofs [6] = '{OFS_CTRL0, OFS_CTRL1, OFS_COUNT, OFS_CMPA, OFS_PERIOD, OFS_FLAGS};
   logic [7:0] cm_c [4] = '{8'h08, 8'h18, 8'h20, 8'h30};
   logic cm_e [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   logic [7:0] pw_c [6] = '{8'hA8, 8'hAC, 8'hAA, 8'h88, 8'h98, 8'hA9};
   logic [15:0] pw_a [6] = '{16'h40, 16'h40, 16'h258, 16'h40, 16'h40, 16'h40};
   int pw_w [6] = '{512, 512, 1200, 512, 512, 512};
   int pw_h [6] = '{128, 384, 512, 0, 512, 128};
   always #25 clk = ~clk;
   tcp_timer tcp_timer_inst (.CORE_CLK(clk), .RST_N(rst_n), .AXI_REQ(req), .AXI_RSP(rsp),
      .TICK_EXT(tick), .TMR_OUT(out), .TMR_OUT_OE(oe));
   tcp_load tcp_load_inst (.clk(clk), .drv(out), .oe(oe), .clr(clr), .pin(pin),
      .hi_cnt(hi_cnt), .edges(edges));
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Both write channels offered together; each dropped at its own handshake
   // Waits as long as the answer takes; only the watchdog ends a hung transfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF,
         bready: 1'b1, default: '0};
      do
      begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end
      while (rsp.bvalid !== 1'b1);
      resp = rsp.bresp;
      req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end
      while (rsp.rvalid !== 1'b1);
      rd_d = rsp.rdata;
      resp = rsp.rresp;
      req.rready <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(nm, rd_d, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse_clr();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask
   // External ticks, each a single-cycle pulse with a quiet cycle after it
   task automatic pulse_tick(input int n);
      repeat (n)
      begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
   endtask
   // Stop, configure, clear flags, then start on the undivided clock
   task automatic cfg(input logic [7:0] c1, input logic [15:0] ca, input logic [7:0] per);
      wr(OFS_CTRL0, 32'h0);
      wr(OFS_CTRL1, {24'h0, c1});
      wr(OFS_CMPA, {16'h0, ca});
      wr(OFS_PERIOD, {24'h0, per});
      wr(OFS_FLAGS, 32'h3);
      wr(OFS_CTRL0, 32'h18);
      pulse_clr();
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ofs[i]) rchk("reset value", ofs[i], 32'h0);
      wr(OFS_PERIOD, 32'h1A5);
      rchk("period", OFS_PERIOD, 32'hA5);
      wr(OFS_CTRL0, 32'hFF);
      rchk("ctrl0", OFS_CTRL0, 32'hF8);
      wr(8'h20, 32'h1);
      chk("bad write resp", 32'(resp), 32'(RESP_SLVERR));
      rchk("bad read data", 8'h18, 32'h0);
      chk("bad read resp", 32'(resp), 32'(RESP_SLVERR));
      $display("test registers done");
      for (int i = 0; i < 4; i++)
      begin
         cfg(cm_c[i], 16'hA, 8'h0);
         cyc(3);
         chk("initial level", 32'(pin), 32'(cm_c[i][3]));
         cyc(30);
         chk("match action", 32'(pin), 32'(cm_e[i]));
         rchk("compare flags", OFS_FLAGS, 32'h1);
      end
      $display("test pin actions done");
      cfg(8'h31, 16'h12C, 8'h1);
      cyc(1000);
      chk("clear on a edges", 32'(edges), 32'h3);
      rchk("clear on a flags", OFS_FLAGS, 32'h1);
      cfg(8'h30, 16'h64, 8'h2);
      cyc(700);
      chk("clear on p edges", 32'(edges), 32'h2);
      rchk("clear on p flags", OFS_FLAGS, 32'h3);
      cfg(8'hC4, 16'hA, 8'h0);
      cyc(30);
      chk("timer enable", 32'(oe), 32'h0);
      chk("timer pin", 32'(pin), 32'h1);
      rchk("timer flags", OFS_FLAGS, 32'h1);
      // Capture mode ignores clear select: P clears at 256 before A can reach 300
      cfg(8'h41, 16'h12C, 8'h1);
      cyc(600);
      rchk("capture flags", OFS_FLAGS, 32'h2);
      $display("test clearing done");
      for (int i = 0; i < 6; i++)
      begin
         cfg(pw_c[i], pw_a[i], 8'h1);
         cyc(300);
         pulse_clr();
         cyc(pw_w[i]);
         chk("pwm high time", 32'(hi_cnt), pw_h[i]);
         rchk("pwm flags", OFS_FLAGS, 32'h3);
      end
      $display("test pwm done");
      wr(OFS_CTRL0, 32'h0);
      wr(OFS_CTRL0, 32'h98);
      rchk("count restart", OFS_COUNT, 32'h0);
      cyc(20);
      rchk("count paused", OFS_COUNT, 32'h0);
      wr(OFS_COUNT, 32'h55);
      rchk("count read only", OFS_COUNT, 32'h0);
      wr(OFS_CTRL0, 32'hC8);
      pulse_tick(3);
      rchk("ext tick paused", OFS_COUNT, 32'h0);
      wr(OFS_CTRL0, 32'h48);
      pulse_tick(5);
      rchk("ext tick count", OFS_COUNT, 32'h5);
      wr(OFS_CTRL0, 32'h40);
      pulse_tick(2);
      rchk("count held", OFS_COUNT, 32'h5);
      $display("test counter done");
      end_of_test();
   end
   initial
   begin
      repeat (30000) @(posedge clk);
      fail_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
